// File: include/failover_wd_consts.svh
// Constants for the upstream failover watchdog: offsets, fields, counts.
// Assumes a 250 MHz core clock and a plain strobe register port.
`ifndef FAILOVER_WD_CONSTS_SVH
`define FAILOVER_WD_CONSTS_SVH

`define WD_CLK_MHZ          250
`define WD_TICK_US          1
`define WD_TICK_CYCLES      (`WD_CLK_MHZ * `WD_TICK_US)
`define WD_COUNT_W          32
`define WD_ADDR_W           4

`define WD_OFS_CONTROL      4'h0
`define WD_OFS_WATCHDOG     4'h4
`define WD_OFS_STATUS       4'h8
`define WD_OFS_IRQ_MASK     4'hC

`define WD_CTL_TIMER_EN_BIT 0
`define WD_STS_CUR_UP_BIT   0
`define WD_STS_CHANGE_BIT   1
`define WD_STS_BUSY_BIT     2
`define WD_STS_MODE_BIT     3

`define WD_IRQ_W            2
`define WD_IRQ_CHANGE_BIT   0
`define WD_IRQ_EXPIRE_BIT   1

`define WD_RST_COUNT        32'h0000_0000
`define WD_RST_MASK         2'h0
`define WD_PORT_A           1'b0
`define WD_PORT_B           1'b1

`endif

// File: include/failover_wd_pkg.sv
// Types for the upstream failover watchdog.
// Assumes failover_wd_consts.svh is on the include path.
`include "failover_wd_consts.svh"
`default_nettype none
package failover_wd_pkg;
  typedef enum logic [1:0] {FoIdle, FoDetect, FoSwap, FoTrain} fo_state_t;
  typedef enum logic [1:0] {TrigNone, TrigWatchdog, TrigOther} trig_t;
endpackage : failover_wd_pkg
`default_nettype wire

// File: logic/us_tick_div.sv
// One-microsecond tick divider for the watchdog countdown.
// Assumes clk at the rate given by WD_CLK_MHZ; tick is a one-cycle pulse.
`include "failover_wd_consts.svh"
`default_nettype none
module us_tick_div (
  input  wire logic clk,
  input  wire logic rst_n,
  output var  logic tick
);
  typedef struct packed {
    logic [7:0] cnt;
    logic       tick;
  } div_st_t;

  localparam logic [7:0] LastCnt = 8'(`WD_TICK_CYCLES - 1);

  div_st_t st_r;
  div_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (st_r.cnt == LastCnt) begin
      st_nxt.cnt = 8'h00;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;

  a_tick_spacing: assert property (@(posedge clk) disable iff (!rst_n)
    tick |=> !tick [*8])
    else $error("tick repeated too soon");
endmodule : us_tick_div
`default_nettype wire

// File: logic/upstream_failover_watchdog.sv
// Upstream failover watchdog: countdown, failover sequencer, registers.
// Assumes a 250 MHz clk, rst_n as fundamental reset, hotReset as a level
// from the switch core, and registers on a plain strobe port.
//
// Implementation choices: the address-and-strobe port and the address map.
`include "failover_wd_consts.svh"
`default_nettype none
// Summary of operation
// - Watchdog failover on count one-to-zero, with enable and failover mode.
// - A non-zero count drops by exactly one per microsecond tick.
// - At zero the count stops and stays at zero.
// - Software writes to the count take effect at once and rearm.
// - Hot reset neither clears nor pauses a running countdown.
// - New upstream port is the one not currently upstream.
// - At zero no further watchdog failover until a non-zero load.
// - Count width gives more than one hour at one microsecond steps.
// - Same-type failover during one in progress is dropped.
// - Other-type failover during one in progress runs afterwards.
// - Each failover sets a sticky change flag kept across hot reset.
// - Failover forces Detect and DL_Down, flushes, swaps lanes, retrains.
module upstream_failover_watchdog
  import failover_wd_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   hotReset,
  input  wire logic                   failoverMode,
  input  wire logic                   initialUpstream,
  input  wire logic                   otherFailoverReq,
  input  wire logic                   trainDone,
  input  wire logic [`WD_ADDR_W-1:0]  regAddr,
  input  wire logic [31:0]            regWdata,
  input  wire logic                   regWr,
  input  wire logic                   regRd,
  output var  logic [31:0]            regRdata,
  output var  logic                   failoverReq,
  output var  logic                   currentUpstreamSelect,
  output var  logic                   forceDetect,
  output var  logic                   dlDown,
  output var  logic                   flushQueues,
  output var  logic                   laneSwap,
  output var  logic                   startTraining,
  output var  logic                   irq
);
  typedef struct packed {
    logic [`WD_COUNT_W-1:0] count;
    logic                   timerFailoverEnable;
    logic                   curUp;
    logic                   upstreamChangeFlag;
    logic [`WD_IRQ_W-1:0]   irqStatus;
    logic [`WD_IRQ_W-1:0]   irqMask;
    fo_state_t              foState;
    trig_t                  activeTrig;
    logic                   pendingOther;
    logic                   pendingWd;
    logic                   strapped;
    logic [31:0]            rdata;
    logic                   failoverReq;
    logic                   forceDetect;
    logic                   dlDown;
    logic                   flushQueues;
    logic                   laneSwap;
    logic                   startTraining;
    logic                   irq;
  } wd_st_t;

  wd_st_t st_r;
  wd_st_t st_nxt;
  logic   tick;

  us_tick_div u_tick (
    .clk   (clk),
    .rst_n (rst_n),
    .tick  (tick)
  );

  logic wrCount;
  logic wdFire;
  logic startWd;
  logic startOther;
  logic [`WD_IRQ_W-1:0] irqSet;

  // Hot reset is deliberately not used here: all of this state survives it.
  always_comb begin
    st_nxt = st_r;
    st_nxt.failoverReq = 1'b0;
    st_nxt.laneSwap = 1'b0;
    st_nxt.startTraining = 1'b0;
    irqSet = '0;
    startWd = 1'b0;
    startOther = 1'b0;
    wrCount = regWr && (regAddr == `WD_OFS_WATCHDOG);

    // Strap the initial upstream port once after fundamental reset release
    if (!st_r.strapped) begin
      st_nxt.strapped = 1'b1;
      st_nxt.curUp = initialUpstream;
    end

    // Countdown: a write wins over the tick
    wdFire = 1'b0;
    if (wrCount) begin
      st_nxt.count = regWdata;
    end else if (tick && (st_r.count != '0)) begin
      st_nxt.count = st_r.count - `WD_COUNT_W'(1);
      if (st_r.count == `WD_COUNT_W'(1)) begin
        wdFire = st_r.timerFailoverEnable && failoverMode;
        irqSet[`WD_IRQ_EXPIRE_BIT] = 1'b1;
      end
    end  // Zero holds: only a write updates it

    if (regWr && (regAddr == `WD_OFS_CONTROL)) begin
      st_nxt.timerFailoverEnable = regWdata[`WD_CTL_TIMER_EN_BIT];
    end
    if (regWr && (regAddr == `WD_OFS_IRQ_MASK)) begin
      st_nxt.irqMask = regWdata[`WD_IRQ_W-1:0];
    end

    // Failover sequencer
    case (st_r.foState)
      FoIdle: begin
        // An expiry held during an other-type failover starts here
        if (wdFire || st_r.pendingWd) begin
          startWd = 1'b1;
        end else if (st_r.pendingOther ||
                     (otherFailoverReq && failoverMode)) begin
          startOther = 1'b1;
        end
        if (startWd && otherFailoverReq && failoverMode) begin
          st_nxt.pendingOther = 1'b1;
        end
      end
      FoDetect: begin
        st_nxt.laneSwap = 1'b1;
        st_nxt.curUp = ~st_r.curUp;
        st_nxt.foState = FoSwap;
      end
      FoSwap: begin
        st_nxt.startTraining = 1'b1;
        st_nxt.forceDetect = 1'b0;
        st_nxt.dlDown = 1'b0;
        st_nxt.flushQueues = 1'b0;
        st_nxt.foState = FoTrain;
      end
      FoTrain: begin
        if (trainDone) begin
          st_nxt.foState = FoIdle;
          st_nxt.activeTrig = TrigNone;
        end
      end
      default: st_nxt.foState = FoIdle;
    endcase

    if (st_r.foState != FoIdle) begin
      // Same type dropped, other type queued
      if (otherFailoverReq && failoverMode &&
          st_r.activeTrig == TrigWatchdog) begin
        st_nxt.pendingOther = 1'b1;
      end
      if (wdFire && st_r.activeTrig == TrigOther) begin
        st_nxt.pendingWd = 1'b1;
      end
      // A watchdog fire while a watchdog failover runs is lost
      // Other-type fire during other-type failover is also lost
    end

    if (startWd || startOther) begin
      st_nxt.foState = FoDetect;
      st_nxt.activeTrig = startWd ? TrigWatchdog : TrigOther;
      if (startOther) begin
        st_nxt.pendingOther = 1'b0;
      end
      if (startWd) begin
        st_nxt.pendingWd = 1'b0;
      end
      st_nxt.failoverReq = 1'b1;
      st_nxt.forceDetect = 1'b1;
      st_nxt.dlDown = 1'b1;
      st_nxt.flushQueues = 1'b1;
      irqSet[`WD_IRQ_CHANGE_BIT] = 1'b1;
    end

    // Sticky flag: set wins over a read-clear in the same cycle
    if (regRd && (regAddr == `WD_OFS_STATUS)) begin
      st_nxt.upstreamChangeFlag = 1'b0;
      st_nxt.irqStatus = '0;
    end
    if (startWd || startOther) begin
      st_nxt.upstreamChangeFlag = 1'b1;
    end
    st_nxt.irqStatus = st_nxt.irqStatus | irqSet;

    // Read data, valid the cycle after the strobe
    st_nxt.rdata = 32'h0000_0000;
    if (regRd) begin
      if (regAddr == `WD_OFS_CONTROL) begin
        st_nxt.rdata[`WD_CTL_TIMER_EN_BIT] = st_r.timerFailoverEnable;
      end else if (regAddr == `WD_OFS_WATCHDOG) begin
        st_nxt.rdata = st_r.count;
      end else if (regAddr == `WD_OFS_STATUS) begin
        st_nxt.rdata[`WD_STS_CUR_UP_BIT] = st_r.curUp;
        st_nxt.rdata[`WD_STS_CHANGE_BIT] = st_r.upstreamChangeFlag;
        st_nxt.rdata[`WD_STS_BUSY_BIT] = (st_r.foState != FoIdle);
        st_nxt.rdata[`WD_STS_MODE_BIT] = failoverMode;
        st_nxt.rdata[7:4] = {2'b00, st_r.irqStatus};
      end else if (regAddr == `WD_OFS_IRQ_MASK) begin
        st_nxt.rdata[`WD_IRQ_W-1:0] = st_r.irqMask;
      end
    end

    st_nxt.irq = |(st_nxt.irqStatus & st_nxt.irqMask);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.count <= `WD_RST_COUNT;
      st_r.irqMask <= `WD_RST_MASK;
      st_r.foState <= FoIdle;
      st_r.activeTrig <= TrigNone;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign regRdata = st_r.rdata;
  assign failoverReq = st_r.failoverReq;
  assign currentUpstreamSelect = st_r.curUp;
  assign forceDetect = st_r.forceDetect;
  assign dlDown = st_r.dlDown;
  assign flushQueues = st_r.flushQueues;
  assign laneSwap = st_r.laneSwap;
  assign startTraining = st_r.startTraining;
  assign irq = st_r.irq;

  // A 32-bit count of microseconds exceeds 3.6e9 us
  localparam longint unsigned MaxUs = (64'h1 << `WD_COUNT_W) - 1;
  localparam bit WideEnough = (MaxUs > 64'd3600000000);

  a_width_hour: assert property (@(posedge clk) WideEnough)
    else $error("count too narrow for one hour");
  a_count_step: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && !wrCount && st_r.count != '0) |=>
    (st_r.count == $past(st_r.count) - 32'h1))
    else $error("count did not drop by one");
  a_zero_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r.count == '0 && !wrCount) |=> (st_r.count == '0))
    else $error("zero count moved");
  a_write_now: assert property (@(posedge clk) disable iff (!rst_n)
    wrCount |=> (st_r.count == $past(regWdata)))
    else $error("count write not taken");
  a_fire_cause: assert property (@(posedge clk) disable iff (!rst_n)
    (wdFire && st_r.foState == FoIdle) |=> failoverReq)
    else $error("watchdog expiry gave no failover");
  a_fire_gate: assert property (@(posedge clk) disable iff (!rst_n)
    wdFire |-> (st_r.timerFailoverEnable && failoverMode &&
                st_r.count == 32'h1))
    else $error("watchdog fired without its cause");
  a_hot_keep: assert property (@(posedge clk) disable iff (!rst_n)
    (hotReset && tick && !wrCount && st_r.count > 32'h1) |=>
    (st_r.count != '0))
    else $error("hot reset cleared the count");
  a_port_swap: assert property (@(posedge clk) disable iff (!rst_n)
    laneSwap |->
    (currentUpstreamSelect != $past(currentUpstreamSelect)))
    else $error("upstream port not swapped");
  a_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
    failoverReq |-> st_r.upstreamChangeFlag)
    else $error("change flag not set");
  a_seq_order: assert property (@(posedge clk) disable iff (!rst_n)
    failoverReq |-> (forceDetect && dlDown && flushQueues)
                    ##1 laneSwap ##1 startTraining)
    else $error("failover sequence out of order");
  a_no_restart: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r.foState != FoIdle) |=> !failoverReq)
    else $error("failover restarted while busy");
  a_wd_queue: assert property (@(posedge clk) disable iff (!rst_n)
    (wdFire && st_r.foState != FoIdle && st_r.activeTrig == TrigOther)
    |=> st_r.pendingWd)
    else $error("expiry during other failover not held");

  c_wd_failover: cover property (@(posedge clk) disable iff (!rst_n)
    wdFire ##1 failoverReq);
  c_queued: cover property (@(posedge clk) disable iff (!rst_n)
    st_r.pendingOther ##[1:20] startOther);
  c_wd_queued: cover property (@(posedge clk) disable iff (!rst_n)
    st_r.pendingWd ##[1:400] startWd);
  c_rearm: cover property (@(posedge clk) disable iff (!rst_n)
    (st_r.count == '0) ##1 wrCount);
endmodule : upstream_failover_watchdog
`default_nettype wire

// File: sim/upstream_failover_watchdog_tb.sv
// Self-checking bench for the upstream failover watchdog.
// Assumes the design and its package are compiled first; 250 MHz clk.
`include "failover_wd_consts.svh"
`default_nettype none
module upstream_failover_watchdog_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TMO = 20000;
  logic        clk, rst_n, hotReset, failoverMode, initialUpstream;
  logic        otherFailoverReq, trainDone, regWr, regRd, port;
  logic [3:0]  regAddr;
  logic [31:0] regWdata, regRdata, d, e;
  logic        failoverReq, currentUpstreamSelect, forceDetect, dlDown;
  logic        flushQueues, laneSwap, startTraining, irq;
  int          error_cnt = 0, checked = 0, cyc = 0, reqCnt = 0;
  int          n, n0, cnt;
  wire  [5:0]  seqBits = {failoverReq, forceDetect, dlDown, flushQueues,
                          laneSwap, startTraining};

  upstream_failover_watchdog i_upstream_failover_watchdog (
    .clk(clk), .rst_n(rst_n), .hotReset(hotReset),
    .failoverMode(failoverMode), .initialUpstream(initialUpstream),
    .otherFailoverReq(otherFailoverReq), .trainDone(trainDone),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .failoverReq(failoverReq),
    .currentUpstreamSelect(currentUpstreamSelect),
    .forceDetect(forceDetect), .dlDown(dlDown),
    .flushQueues(flushQueues), .laneSwap(laneSwap),
    .startTraining(startTraining), .irq(irq)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Pulses are counted one edge late, which is fine for long windows
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (failoverReq === 1'b1) reqCnt <= reqCnt + 1;
    if (cyc == TMO) begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= v;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 v = regRdata;
  endtask : rd

  task automatic waitReq(input int lim);
    n = 0;
    while (failoverReq !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask : waitReq

  // Sel 0 pulses the other-type request, sel 1 the retrain done
  task automatic pulse(input bit sel);
    @(posedge clk);
    if (sel) trainDone <= 1'b1;
    else otherFailoverReq <= 1'b1;
    @(posedge clk);
    trainDone <= 1'b0;
    otherFailoverReq <= 1'b0;
  endtask : pulse

  // Entered at the cycle that shows the request pulse
  task automatic fireCheck;
    chk(seqBits, 6'h3C);
    @(negedge clk);
    chk(seqBits, 6'h1E);
    chk(currentUpstreamSelect, !port);
    port = !port;
    @(negedge clk);
    chk(seqBits, 6'h01);
  endtask : fireCheck

  function automatic logic [5:0] stsExp(logic chg, logic p);
    return {chg, chg, 1'b1, 1'b0, chg, p};
  endfunction : stsExp

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    void'($urandom(41303));
    {rst_n, hotReset, failoverMode, otherFailoverReq, trainDone} = 5'h00;
    {regWr, regRd, regAddr, regWdata} = 38'h0;
    initialUpstream = 1'($urandom % 2);
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    port = initialUpstream;
    rd(`WD_OFS_WATCHDOG, d);
    chk(d, 32'h0);
    rd(`WD_OFS_CONTROL, d);
    chk(d, 32'h0);
    rd(`WD_OFS_STATUS, d);
    chk(d[5:0], {5'h00, port});
    rd(4'h2, d);
    chk(d, 32'h0);
    $display("test reset done");
    // Exactly 250 edges apart, so exactly one tick lands between reads
    for (int i = 0; i < 6; i++) begin
      @(posedge clk) hotReset <= i[0];
      e = (i == 0) ? 32'hFFFF_FFFF : ($urandom | 32'h1000);
      wr(`WD_OFS_WATCHDOG, e);
      rd(`WD_OFS_WATCHDOG, d);
      chk(32'(d >= e - 1 && d <= e), 32'h1);
      repeat (248) @(posedge clk);
      rd(`WD_OFS_WATCHDOG, e);
      chk(d - e, 32'h1);
    end
    $display("test count done");
    for (int i = 0; i < 3; i++) begin
      wr(`WD_OFS_CONTROL, 32'(i[1]));
      @(posedge clk) failoverMode <= i[0];
      n0 = reqCnt;
      wr(`WD_OFS_WATCHDOG, 32'h2);
      repeat (760) @(negedge clk);
      chk(reqCnt - n0, 32'h0);
      rd(`WD_OFS_WATCHDOG, d);
      chk(d, 32'h0);
      rd(`WD_OFS_STATUS, d);
      chk(d[5], 1'b1);
    end
    wr(`WD_OFS_CONTROL, 32'h1);
    @(posedge clk) failoverMode <= 1'b1;
    n0 = reqCnt;
    repeat (600) @(negedge clk);
    chk(reqCnt - n0, 32'h0);
    wr(`WD_OFS_IRQ_MASK, 32'h3);
    $display("test gating done");
    cnt = 2 + $urandom % 3;
    @(posedge clk) hotReset <= 1'b1;
    wr(`WD_OFS_WATCHDOG, 32'(cnt));
    waitReq(cnt * 250 + 10);
    e = 32'(n >= (cnt - 1) * 250 && n <= cnt * 250 + 2);
    chk(e, 32'h1);
    fireCheck();
    pulse(1'b0);
    rd(`WD_OFS_WATCHDOG, d);
    chk(d, 32'h0);
    pulse(1'b1);
    waitReq(20);
    chk(32'(n < 20), 32'h1);
    fireCheck();
    n0 = reqCnt;
    pulse(1'b0);
    pulse(1'b1);
    repeat (40) @(negedge clk);
    chk(reqCnt - n0, 32'h0);
    chk(irq, 1'b1);
    rd(`WD_OFS_STATUS, d);
    chk(d[5:0], stsExp(1'b1, port));
    repeat (3) @(negedge clk);
    chk(irq, 1'b0);
    rd(`WD_OFS_STATUS, d);
    chk(d[5:0], stsExp(1'b0, port));
    $display("test expiry done");
    // Masked events must stay off the interrupt line until unmasked
    wr(`WD_OFS_IRQ_MASK, 32'h0);
    @(posedge clk) hotReset <= 1'b0;
    wr(`WD_OFS_WATCHDOG, 32'h1);
    waitReq(260);
    chk(32'(n <= 252), 32'h1);
    fireCheck();
    pulse(1'b1);
    repeat (3) @(negedge clk);
    chk(irq, 1'b0);
    wr(`WD_OFS_IRQ_MASK, 32'h3);
    repeat (3) @(negedge clk);
    chk(irq, 1'b1);
    rd(`WD_OFS_STATUS, d);
    chk(d[5:0], stsExp(1'b1, port));
    repeat (3) @(negedge clk);
    chk(irq, 1'b0);
    $display("test rearm done");
    // An expiry during an other-type failover waits for it to finish
    pulse(1'b0);
    waitReq(10);
    chk(32'(n < 10), 32'h1);
    fireCheck();
    n0 = reqCnt;
    wr(`WD_OFS_WATCHDOG, 32'h1);
    repeat (260) @(negedge clk);
    chk(reqCnt - n0, 32'h0);
    pulse(1'b1);
    waitReq(20);
    chk(32'(n < 20), 32'h1);
    fireCheck();
    pulse(1'b1);
    $display("test queue done");
    complete_run();
  end
endmodule : upstream_failover_watchdog_tb
`default_nettype wire
